// ==== logic/smb_bank.sv ====
`include "smb_regs.svh"
// shared memory bank controller with one memory port
module smb_bank (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // axi4-lite slave
  input  wire logic [11:0]           i_awaddr,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [11:0]           i_araddr,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  // global request from master bus driver
  input  wire logic                  i_global_req,
  input  wire logic [23:0]           i_global_addr,
  input  wire logic                  i_master_refresh,
  output logic                       o_global_gnt,
  // memory source through the port
  input  wire smb_pkg::smb_src_type  i_src,
  output smb_pkg::smb_ans_type       o_ans,
  // local dma requesters, bit 0 nearest the controller
  input  wire logic [3:0]            i_dma_req,
  output logic [3:0]                 o_dma_gnt,
  // memory side
  output logic                       o_mem_cyc,
  output logic                       o_mem_write,
  output logic                       o_mem_refresh,
  output logic [23:0]                o_mem_addr,
  output logic [17:0]                o_mem_wdata,
  input  wire logic [17:0]           i_mem_rdata,
  input  wire logic                  i_mem_multi_err,
  // power and interrupts
  input  wire logic                  i_power_fail,
  output logic [3:0]                 o_irq_level,
  output logic                       o_irq,
  output logic                       o_transparent,
  output logic [23:0]                o_display
);
  import smb_pkg::*;

  //----------------------------------------------------------
  // state types
  //----------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CYC  = 3'b010,
    ST_DONE = 3'b100
  } smb_st_type;

  // requester identities
  localparam logic [2:0] WHO_GLB = 3'h0;
  localparam logic [2:0] WHO_PORT = 3'h1;
  localparam logic [2:0] WHO_DMA = 3'h2;
  localparam logic [2:0] WHO_REF = 3'h3;
  localparam int CYC_CLKS = `SMB_CYC_CLKS;
  localparam int REF_CLKS = `SMB_REF_CLKS;

  //----------------------------------------------------------
  // functions
  //----------------------------------------------------------
  // odd parity for one byte: parity bit makes ones count odd
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~(^b);
  endfunction
  // check both byte parities of an 18-bit word
  function automatic logic par_bad(input logic [17:0] w);
    par_bad = (w[16] != odd_par(w[7:0])) || (w[17] != odd_par(w[15:8]));
  endfunction

  //----------------------------------------------------------
  // registers
  //----------------------------------------------------------
  logic [31:0] ctrl_r;         // control word
  logic [31:0] tdata_r;        // test data
  logic [7:0]  lower_r;        // lower limit, 64 kword units
  logic [7:0]  upper_r;        // upper limit
  logic [7:0]  base_r;         // base limit
  smb_pes_type pes_r;          // error status
  logic [23:0] pea_r;          // error address
  smb_st_type  st_r;           // memory cycle state
  logic [2:0]  who_r;          // current owner
  logic [3:0]  dma_sel_r;      // granted dma one-hot
  logic [5:0]  cnt_r;          // cycle counter
  logic [13:0] ref_cnt_r;      // refresh interval counter
  logic        prio_glb_r;     // global has priority next
  logic        lock_r;         // held second cycle pending
  logic [23:0] cyc_addr_r;     // address of current cycle
  logic        cyc_wr_r;       // current cycle writes
  logic        port_busy_r;    // port access accepted, waiting

  //----------------------------------------------------------
  // address window and translation
  //----------------------------------------------------------
  wire [23:0] lo_addr   = {lower_r, 16'h0000};  // [RULE_14]
  wire [23:0] up_addr   = {upper_r, 16'h0000};
  wire [23:0] base_addr = {base_r, 16'h0000};
  wire in_win = (i_src.addr >= lo_addr) && (i_src.addr < up_addr); // [RULE_12] [RULE_22]
  wire [23:0] port_local = i_src.addr - lo_addr + base_addr;       // [RULE_13]
  wire port_req = i_src.req && in_win && !port_busy_r && !ctrl_r[`SMB_CTRL_IOONLY];
  wire glb_req  = i_global_req && !ctrl_r[`SMB_CTRL_IOONLY];       // [RULE_11]
  wire dma_any  = |i_dma_req;
  wire loc_req  = port_req || dma_any;                             // [RULE_01]
  // nearest requester first: port sits closest, then dma bit 0
  wire [3:0] dma_pick = i_dma_req & (~i_dma_req + 4'h1);           // [RULE_03]
  wire ref_due = (ref_cnt_r == '0);                                // [RULE_04]
  wire take_glb = glb_req && (prio_glb_r || !loc_req);             // [RULE_02]
  wire cyc_end  = (st_r == ST_CYC) && (cnt_r == 6'(CYC_CLKS - 1));
  wire wpar_err = cyc_wr_r && (who_r == WHO_PORT) &&
                  ctrl_r[`SMB_CTRL_WPAR_EN] && par_bad(o_mem_wdata); // [RULE_15]
  wire rd_err   = !cyc_wr_r && i_mem_multi_err;                    // [RULE_16]

  //----------------------------------------------------------
  // axi4-lite decode
  //----------------------------------------------------------
  wire wr_go = i_awvalid && i_wvalid && !o_bvalid;
  wire rd_go = i_arvalid && !o_rvalid;
  wire [11:0] rwa = i_araddr;
  wire rd_hit = (rwa <= `SMB_OFF_TDATA) && (rwa[1:0] == 2'b00);
  wire wr_hit = (i_awaddr == `SMB_OFF_CTRL) || (i_awaddr == `SMB_OFF_TDATA) ||
                (i_awaddr == `SMB_OFF_LOWER) || (i_awaddr == `SMB_OFF_UPPER) ||
                (i_awaddr == `SMB_OFF_BASE);
  logic [31:0] rd_mux;
  always_comb begin
    // read data select
    unique case (rwa)
      `SMB_OFF_PES:    rd_mux = {28'h0, pes_r};                     // [RULE_09]
      `SMB_OFF_PEA:    rd_mux = {8'h00, pea_r};
      `SMB_OFF_LOWER:  rd_mux = {24'h0, lower_r};
      `SMB_OFF_UPPER:  rd_mux = {24'h0, upper_r};
      `SMB_OFF_BASE:   rd_mux = {24'h0, base_r};
      `SMB_OFF_TEST:   rd_mux = tdata_r;
      `SMB_OFF_STATUS: rd_mux = {26'h0, st_r, prio_glb_r, lock_r, i_power_fail};
      `SMB_OFF_CTRL:   rd_mux = ctrl_r;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end
  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
  endfunction

  //----------------------------------------------------------
  // bus slave
  //----------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'b00;
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rresp   <= 2'b00;
      o_rdata   <= 32'h0000_0000;
      ctrl_r    <= `SMB_CTRL_RST;
      tdata_r   <= 32'h0000_0000;
      lower_r   <= `SMB_LOWER_RST;
      upper_r   <= `SMB_UPPER_RST;
      base_r    <= `SMB_BASE_RST;
    end else begin
      o_awready <= wr_go && !o_awready;
      o_wready  <= wr_go && !o_wready;
      o_arready <= rd_go && !o_arready;
      if (wr_go && !o_awready) begin
        // write taken with both address and data present
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? 2'b00 : 2'b10;
        if (i_awaddr == `SMB_OFF_CTRL) ctrl_r <= merge(ctrl_r, i_wdata, i_wstrb);   // [RULE_10]
        if (i_awaddr == `SMB_OFF_TDATA) tdata_r <= merge(tdata_r, i_wdata, i_wstrb); // [RULE_10]
        if (i_awaddr == `SMB_OFF_LOWER && i_wstrb[0]) lower_r <= i_wdata[7:0];
        if (i_awaddr == `SMB_OFF_UPPER && i_wstrb[0]) upper_r <= i_wdata[7:0];
        if (i_awaddr == `SMB_OFF_BASE && i_wstrb[0]) base_r <= i_wdata[7:0];
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (rd_go && !o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_mux;
        o_rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------
  // arbiter and memory cycle sequencer
  //----------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r          <= ST_IDLE;
      who_r         <= WHO_GLB;
      dma_sel_r     <= 4'h0;
      cnt_r         <= 6'h00;
      ref_cnt_r     <= 14'(REF_CLKS - 1);
      prio_glb_r    <= 1'b0;
      lock_r        <= 1'b0;
      cyc_addr_r    <= 24'h000000;
      cyc_wr_r      <= 1'b0;
      port_busy_r   <= 1'b0;
      o_global_gnt  <= 1'b0;
      o_dma_gnt     <= 4'h0;
      o_mem_cyc     <= 1'b0;
      o_mem_write   <= 1'b0;
      o_mem_refresh <= 1'b0;
      o_mem_addr    <= 24'h000000;
      o_mem_wdata   <= 18'h00000;
      o_ans         <= '0;
      pes_r         <= '0;
      pea_r         <= 24'h000000;
    end else begin
      // refresh timer restarts on master refresh or on expiry while idle, holds at zero when expired outside idle, else runs down
      if (i_master_refresh || (st_r == ST_IDLE && ref_due)) ref_cnt_r <= 14'(REF_CLKS - 1);
      else if (!ref_due) ref_cnt_r <= ref_cnt_r - 14'h0001;               // [RULE_04]
      o_ans.addr_accepted <= 1'b0;
      o_ans.data_done     <= 1'b0;
      if (!i_src.req) port_busy_r <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          // pick a requester; a held port keeps its grant
          st_r  <= ST_CYC;
          cnt_r <= 6'h00;
          if (lock_r && port_req) begin                                    // [RULE_23] [RULE_19]
            who_r <= WHO_PORT;
          end else if (ref_due && !i_master_refresh) begin                 // [RULE_05]
            who_r <= WHO_REF;
            o_mem_refresh <= 1'b1;
          end else if (take_glb && !lock_r) begin
            who_r        <= WHO_GLB;
            cyc_addr_r   <= i_global_addr;
            o_global_gnt <= 1'b1;
            prio_glb_r   <= 1'b0;                                          // [RULE_02]
          end else if (port_req && !lock_r) begin
            who_r      <= WHO_PORT;
            prio_glb_r <= 1'b1;
          end else if (dma_any && !lock_r) begin
            who_r      <= WHO_DMA;
            dma_sel_r  <= dma_pick;                                        // [RULE_03]
            o_dma_gnt  <= dma_pick;
            prio_glb_r <= 1'b1;
          end else begin
            st_r <= ST_IDLE;
          end
          if ((lock_r || !(ref_due && !i_master_refresh) && !take_glb) && port_req) begin
            cyc_addr_r          <= port_local;
            cyc_wr_r            <= i_src.write;
            o_mem_wdata         <= i_src.data;                             // [RULE_18]
            port_busy_r         <= 1'b1;
            o_ans.addr_accepted <= 1'b1;                                   // [RULE_20]
            lock_r              <= i_src.hold && !lock_r;                  // [RULE_19]
          end else if (!(lock_r && port_req)) begin
            cyc_wr_r <= 1'b0;
            // a held lock ends when the source drops its hold or when its held second cycle is taken
            if (!i_src.hold) lock_r <= 1'b0;                               // [RULE_19]
          end
          o_mem_cyc   <= 1'b0;
        end
        ST_CYC: begin
          // drive the memory for one cycle time
          o_mem_cyc   <= (who_r != WHO_REF);
          o_mem_write <= cyc_wr_r;
          o_mem_addr  <= cyc_addr_r;
          cnt_r       <= cnt_r + 6'h01;
          if (cyc_end) st_r <= ST_DONE;
        end
        ST_DONE: begin
          // finish: answer the port, record errors
          if (who_r == WHO_PORT) begin
            o_ans.data_done <= 1'b1;
            o_ans.par_err   <= rd_err || wpar_err;                         // [RULE_16]
            o_ans.data      <= i_mem_rdata;                                // [RULE_17]
          end
          if ((wpar_err || rd_err) && !pes_r.valid) begin
            pes_r <= '{valid: 1'b1, write_par: wpar_err, read_multi: rd_err,
                       from_global: (who_r == WHO_GLB)};                   // [RULE_08]
            pea_r <= cyc_addr_r;
          end
          o_global_gnt  <= 1'b0;
          o_dma_gnt     <= 4'h0;
          dma_sel_r     <= 4'h0;
          o_mem_cyc     <= 1'b0;
          o_mem_refresh <= 1'b0;
          st_r          <= ST_IDLE;
        end
      endcase
    end
  end

  //----------------------------------------------------------
  // interrupt, display and transparency outputs
  //----------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq         <= 1'b0;
      o_irq_level   <= 4'h0;
      o_transparent <= 1'b0;
      o_display     <= 24'h000000;
    end else begin
      o_transparent <= ctrl_r[`SMB_CTRL_IOONLY];                           // [RULE_11]
      o_display     <= {lower_r, upper_r, base_r};                         // [RULE_21]
      if (i_power_fail) begin
        o_irq       <= 1'b1;
        o_irq_level <= ctrl_r[`SMB_CTRL_CRIT] ? `SMB_IRQ_LVL_HI : `SMB_IRQ_LVL_LO; // [RULE_06] [RULE_07]
      end else if (pes_r.valid && ctrl_r[`SMB_CTRL_ERR_EN]) begin
        o_irq       <= 1'b1;
        o_irq_level <= `SMB_IRQ_LVL_LO;                                    // [RULE_08]
      end else begin
        o_irq       <= 1'b0;
        o_irq_level <= 4'h0;
      end
    end
  end

  //----------------------------------------------------------
  // assertions
  //----------------------------------------------------------
  pf_level_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_07]
    i_power_fail |=> o_irq && o_irq_level == ($past(ctrl_r[`SMB_CTRL_CRIT]) ? 4'he : 4'hd))
    else $error("power fail level wrong");
  accept_win_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_22]
    $rose(o_ans.addr_accepted) |-> $past(in_win))
    else $error("out of window access accepted");
  trans_addr_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_13]
    (st_r == ST_IDLE && o_ans.addr_accepted == 1'b0 && port_req && !take_glb && !ref_due)
    |=> cyc_addr_r == $past(port_local))
    else $error("local address wrong");
  done_after_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_20]
    o_ans.addr_accepted |-> ##[1:40] o_ans.data_done)
    else $error("no data done after accept");
  dma_onehot_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_03]
    $onehot0(o_dma_gnt))
    else $error("several dma grants");
  rd_err_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_16]
    (st_r == ST_DONE && who_r == WHO_PORT && rd_err) |=> o_ans.par_err)
    else $error("read error not flagged");
  err_cap_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_08]
    (st_r == ST_DONE && (rd_err || wpar_err)) |=> pes_r.valid)
    else $error("error not captured");
  display_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_21]
    ##1 o_display == $past({lower_r, upper_r, base_r}))
    else $error("display stale");
  lock_hold_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_23]
    (st_r == ST_IDLE && lock_r) |=> !o_global_gnt && o_dma_gnt == 4'h0)
    else $error("held grant lost");
endmodule

// ==== logic/smb_regs.svh ====
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// [RULE_01] accept global and local memory requests
// [RULE_02] alternate priority between global and local
// [RULE_03] nearest local requester wins among locals
// [RULE_04] self refresh when master refresh missing
// [RULE_05] keep serving locals without master
// [RULE_06] power failure interrupt level 13/14
// [RULE_07] critical switch on gives 14, else 13
// [RULE_08] capture failing address and error status
// [RULE_09] master reads status, address, limits, test
// [RULE_10] master writes control word and test data
// [RULE_11] io-only bank acts as transparent extension
// [RULE_12] only in-window source accesses reach bank
// [RULE_13] local = source - lower + base
// [RULE_14] base step is 64 Kwords
// [RULE_15] write parity checked only when enabled
// [RULE_16] read errors always flagged to source
// [RULE_17] odd parity per byte, both directions
// [RULE_18] 24-bit address, 16 data plus 2 parity
// [RULE_19] hold signal keeps bus for two cycles
// [RULE_20] address accepted pulse before next request
// [RULE_21] display lower, upper and base settings
// [RULE_22] window includes lower, excludes upper
// [RULE_23] held grant kept through following cycle

//------------------------------------------------------------
// register byte offsets
//------------------------------------------------------------
`define SMB_OFF_PES      12'h000
`define SMB_OFF_PEA      12'h004
`define SMB_OFF_LOWER    12'h008
`define SMB_OFF_UPPER    12'h00c
`define SMB_OFF_BASE     12'h010
`define SMB_OFF_TEST     12'h014
`define SMB_OFF_STATUS   12'h018
`define SMB_OFF_CTRL     12'h01c
`define SMB_OFF_TDATA    12'h020
// control word fields
`define SMB_CTRL_ERR_EN  0
`define SMB_CTRL_WPAR_EN 1
`define SMB_CTRL_CRIT    2
`define SMB_CTRL_IOONLY  3
// reset values
`define SMB_CTRL_RST     32'h0000_0000
`define SMB_LOWER_RST    8'h00
`define SMB_UPPER_RST    8'h00
`define SMB_BASE_RST     8'h00
// limit step is 64 Kwords = 2**16 words
`define SMB_STEP_SHIFT   16
// memory cycle length and refresh interval
`define SMB_CYC_NS       500
`define SMB_CLK_NS       20
`define SMB_CYC_CLKS     ((`SMB_CYC_NS) / (`SMB_CLK_NS))
`define SMB_REF_NS       15000
`define SMB_REF_CLKS     ((`SMB_REF_NS) / (`SMB_CLK_NS))
`define SMB_IRQ_LVL_LO   4'hd
`define SMB_IRQ_LVL_HI   4'he
`endif

// ==== logic/smb_pkg.sv ====
package smb_pkg;
  // one source access as presented at the port
  typedef struct packed {
    logic        req;
    logic        write;
    logic        hold;
    logic [23:0] addr;
    logic [17:0] data;
  } smb_src_type;
  // port answer to the source
  typedef struct packed {
    logic        addr_accepted;
    logic        data_done;
    logic        par_err;
    logic [17:0] data;
  } smb_ans_type;
  // error capture status
  typedef struct packed {
    logic       valid;
    logic       write_par;
    logic       read_multi;
    logic       from_global;
  } smb_pes_type;
endpackage

// ==== tb/smb_source.sv ====
// requesting source on the far side of the memory port
module smb_source (
  input  wire logic                 i_clk,
  input  wire logic                 i_go,
  input  wire logic                 i_write,
  input  wire logic [23:0]          i_addr,
  input  wire logic [17:0]          i_data,
  input  wire logic                 i_hold,
  input  wire smb_pkg::smb_ans_type i_ans,
  output smb_pkg::smb_src_type      o_src,
  output logic                      o_busy,
  output logic                      o_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  import smb_pkg::*;
  int n;
  //------------------------------------------------------------
  // one access: request until accepted, then wait for done
  //------------------------------------------------------------
  initial begin
    o_src = '0;
    o_busy = 1'b0;
    o_taken = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        o_src <= {1'b1, i_write, i_hold, i_addr, i_data};
        for (n = 0; n < 60 && !i_ans.addr_accepted; n++) @(posedge i_clk);
        o_taken <= i_ans.addr_accepted;
        o_src.req <= 1'b0;
        o_src.addr <= ~i_addr;
        if (i_ans.addr_accepted) begin
          for (n = 0; n < 60 && !i_ans.data_done; n++) @(posedge i_clk);
        end
        o_src.data <= ~i_data;
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// ==== tb/shared_memory_bank_port_bench.sv ====
`include "smb_regs.svh"
module shared_memory_bank_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import smb_pkg::*;
  //------------------------------------------------------------
  // signals
  //------------------------------------------------------------
  logic        i_clk, i_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, go, sw, busy, taken;
  logic        multi, pfail, irq, transp, mcyc, mwr, mref, last_wr, greq, ggnt, mrf, hold;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  dma_req, dma_gnt, lvl;
  logic [23:0] sa, maddr, disp, last_addr;
  logic [17:0] sd, mwdata;
  smb_src_type src;
  smb_ans_type ans;
  int          num_errors, check_count, n;

  smb_bank DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_global_req(greq),
    .i_global_addr(24'h000000), .i_master_refresh(mrf), .o_global_gnt(ggnt),
    .i_src(src), .o_ans(ans), .i_dma_req(dma_req), .o_dma_gnt(dma_gnt),
    .o_mem_cyc(mcyc), .o_mem_write(mwr), .o_mem_refresh(mref), .o_mem_addr(maddr),
    .o_mem_wdata(mwdata), .i_mem_rdata(18'h21234), .i_mem_multi_err(multi),
    .i_power_fail(pfail), .o_irq_level(lvl), .o_irq(irq), .o_transparent(transp),
    .o_display(disp));

  smb_source SRC (.i_clk(i_clk), .i_go(go), .i_write(sw), .i_addr(sa), .i_data(sd),
    .i_hold(hold), .i_ans(ans), .o_src(src), .o_busy(busy), .o_taken(taken));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // last memory cycle that was not a refresh
  always @(posedge i_clk) if (mcyc && !mref) begin
    last_addr <= maddr;
    last_wr <= mwr;
  end
  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic [17:0] gp(input logic [15:0] v);
    return {~^v[15:8], ~^v[7:0], v};
  endfunction
  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tmo(input string m);
    chk(32'h0, 32'h1, m);
    give_verdict();
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) tmo("write hang");
  endtask
  task automatic axi_rd(input logic [11:0] a);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) tmo("read hang");
  endtask
  task automatic access(input logic w, input logic [23:0] a, input logic [17:0] v);
    @(posedge i_clk);
    go <= 1'b1;
    sw <= w;
    sa <= a;
    sd <= v;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    for (n = 0; n < 200 && busy !== 1'b0; n++) @(posedge i_clk);
    if (n == 200) tmo("source hang");
  endtask
  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_regs();
    axi_rd(`SMB_OFF_CTRL);
    chk(d, 32'h0, "ctrl reset");
    axi_rd(12'h0fc);
    chk({30'h0, r}, 32'h2, "unmapped resp");
    axi_wr(`SMB_OFF_LOWER, 32'h1);
    axi_wr(`SMB_OFF_UPPER, 32'h3);
    axi_wr(`SMB_OFF_BASE, 32'h5);
    axi_rd(`SMB_OFF_UPPER);
    chk(d, 32'h3, "limit readback");
    chk({8'h0, disp}, 32'h010305, "display");
    axi_wr(`SMB_OFF_CTRL, 32'h8);
    @(posedge i_clk);
    chk({31'h0, transp}, 32'h1, "io only");
    axi_wr(`SMB_OFF_CTRL, 32'h0);
  endtask
  task automatic t_refresh();
    mrf <= 1'b1;
    for (n = 0; n < 800 && mref !== 1'b1; n++) @(posedge i_clk);
    chk({31'h0, mref}, 32'h0, "master refresh");
    mrf <= 1'b0;
    for (n = 0; n < 800 && mref !== 1'b1; n++) @(posedge i_clk);
    chk({31'h0, mref}, 32'h1, "self refresh");
  endtask
  task automatic t_dma();
    dma_req <= 4'b0110;
    for (n = 0; n < 100 && dma_gnt === 4'h0; n++) @(posedge i_clk);
    chk({28'h0, dma_gnt}, 32'h2, "nearest first");
    dma_req <= 4'b0100;
    for (n = 0; n < 100 && dma_gnt !== 4'b0100; n++) @(posedge i_clk);
    chk({28'h0, dma_gnt}, 32'h4, "next requester");
    dma_req <= 4'b0000;
    for (n = 0; n < 100 && dma_gnt !== 4'h0; n++) @(posedge i_clk);
  endtask
  task automatic t_access();
    access(1'b1, 24'h012345, gp(16'habcd));
    chk({31'h0, taken}, 32'h1, "in window");
    chk({8'h0, last_addr}, 32'h052345, "local addr");
    chk({31'h0, last_wr}, 32'h1, "write cycle");
    access(1'b0, 24'h02ffff, 18'h0);
    chk({14'h0, ans.data}, {14'h0, gp(16'h1234)}, "read data");
    chk({31'h0, ans.par_err}, 32'h0, "clean read");
    access(1'b0, 24'h030000, 18'h0);
    chk({31'h0, taken}, 32'h0, "upper excluded");
    access(1'b0, 24'h00ffff, 18'h0);
    chk({31'h0, taken}, 32'h0, "below lower");
    access(1'b1, 24'h010000, 18'h01234);
    chk({31'h0, ans.par_err}, 32'h0, "wpar off");
    axi_wr(`SMB_OFF_CTRL, 32'h2);
    access(1'b1, 24'h010000, 18'h01234);
    chk({31'h0, ans.par_err}, 32'h1, "wpar on");
    axi_wr(`SMB_OFF_CTRL, 32'h0);
    multi <= 1'b1;
    access(1'b0, 24'h010000, 18'h0);
    chk({31'h0, ans.par_err}, 32'h1, "multi err");
    multi <= 1'b0;
    axi_rd(`SMB_OFF_PES);
    chk({31'h0, |d}, 32'h1, "status captured");
  endtask
  task automatic t_lock();
    hold <= 1'b1;
    access(1'b1, 24'h010010, gp(16'h5a5a));
    dma_req <= 4'h1;
    repeat (5) @(posedge i_clk);
    chk({28'h0, dma_gnt}, 32'h0, "lock kept");
    hold <= 1'b0;
    access(1'b0, 24'h010010, 18'h0);
    chk({31'h0, taken}, 32'h1, "held cycle");
    dma_req <= 4'h0;
    for (n = 0; n < 100 && dma_gnt !== 4'h0; n++) @(posedge i_clk);
  endtask
  task automatic t_glb();
    {greq, dma_req} <= 5'h11;
    for (n = 0; n < 100 && ggnt !== 1'b1; n++) @(posedge i_clk);
    for (n = 0; n < 100 && (ggnt === 1'b1 || dma_gnt === 4'h0); n++) @(posedge i_clk);
    chk({27'h0, ggnt, dma_gnt}, 32'h1, "local after global");
    {greq, dma_req} <= 5'h00;
    for (n = 0; n < 100 && dma_gnt !== 4'h0; n++) @(posedge i_clk);
  endtask
  task automatic t_irq();
    pfail <= 1'b1;
    for (n = 0; n < 100 && !(irq === 1'b1 && lvl === 4'hd); n++) @(posedge i_clk);
    chk({28'h0, lvl}, 32'hd, "level 13");
    axi_wr(`SMB_OFF_CTRL, 32'h4);
    for (n = 0; n < 100 && lvl !== 4'he; n++) @(posedge i_clk);
    chk({28'h0, lvl}, 32'he, "level 14");
    pfail <= 1'b0;
    axi_wr(`SMB_OFF_CTRL, 32'h1);
    for (n = 0; n < 100 && !(irq === 1'b1 && lvl === 4'hd); n++) @(posedge i_clk);
    chk({28'h0, lvl}, 32'hd, "error level");
  endtask
  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    {i_rst, awvalid, wvalid, bready, arvalid, rready, go, sw, multi, pfail} = 10'h200;
    {awaddr, araddr, wdata, dma_req, sa, sd, greq, mrf, hold} = '0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    t_regs();
    t_refresh();
    t_dma();
    t_access();
    t_lock();
    t_glb();
    t_irq();
    give_verdict();
  end
endmodule
